/* src/tmq_pkg.sv */
package tmq_pkg;
    // count register address and layout
    localparam logic [7:0] TIMER_COUNT_ADDR  = 8'h01;
    localparam int         COUNT_W           = 8;
    // option word fields and value after reset
    localparam int         OPT_CLOCK_SRC_BIT = 5;
    localparam int         OPT_EDGE_BIT      = 4;
    localparam int         OPT_ASSIGN_BIT    = 3;
    localparam int         OPT_RATIO_LSB     = 0;
    localparam int         OPT_RATIO_W       = 3;
    localparam logic [7:0] OPTION_RESET      = 8'hff;
    localparam logic [5:0] DIR_RESET         = 6'h3f;
    localparam logic [7:0] PRESCALER_RESET   = 8'h00;
    // instruction cycle is four phases of the oscillator clock
    localparam int         PHASES_PER_CYCLE  = 4;
    localparam logic [1:0] PHASE_FIRST       = 2'd0;
    localparam logic [1:0] PHASE_SECOND      = 2'd1;
    localparam logic [1:0] PHASE_FOURTH      = 2'd3;
    localparam logic [1:0] INHIBIT_CYCLES    = 2'd2;
    localparam int         PRESCALER_W       = 8;
endpackage

/* src/tmq_phase_gen.sv */
`timescale 1ns/1ps
// four-phase sequencer: each clk_i edge is one oscillator period
module tmq_phase_gen (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    output logic [1:0]      phase_o,
    output logic            cycle_end_o
);
    logic [1:0] phase_r;

    // free running phase counter, wraps after the fourth phase
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_r <= tmq_pkg::PHASE_FIRST;
        end else begin
            phase_r <= phase_r + 2'd1;
        end
    end

    assign phase_o     = phase_r;
    assign cycle_end_o = (phase_r == tmq_pkg::PHASE_FOURTH);
endmodule

/* src/tmq_prescaler.sv */
`timescale 1ns/1ps
// shared 8-bit divider, no read or write path from software
module tmq_prescaler #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             clear_i,
    input  wire logic             tick_i,
    output logic [WIDTH-1:0]      count_o
);
    logic [WIDTH-1:0] count_r;

    // clear beats tick; zero on reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_r <= '0;
        end else if (clear_i) begin
            count_r <= '0;
        end else if (tick_i) begin
            count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign count_o = count_r;
endmodule

/* src/tmq_timer.sv */
// Contract
// - select bit low: timer mode, one increment per instruction cycle without prescaler.
// - after a count write, no counting for two instruction cycles, then resume.
// - select bit high: counter mode, counts edges of the external pin.
// - edge bit low counts rising edges, high counts falling edges.
// - prescaler serves timer or watchdog only; assign bit zero gives it to timer.
// - timer prescale ratios run 1:2 to 1:256 in power-of-two steps.
// - prescaler is an 8-bit counter, prescaler or watchdog postscaler.
// - software cannot read or load the prescaler.
// - count writes clear the prescaler while it belongs to the timer.
// - watchdog clear clears prescaler while it belongs to the watchdog.
// - any reset zeroes the prescaler.
// - counter mode samples the clock source in second and fourth phases.
// - count increments three to seven periods after an effective pin change; here two to four without the prescaler, three to five with it.
// - count is 8-bit read/write at address 01h, kept over reset.
// - select bit high overrides the pin direction to input.
`timescale 1ns/1ps
module tmq_timer #(
    parameter int COUNT_W     = 8,
    parameter int PRESCALER_W = 8
) (
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [7:0]          reg_wdata_i,
    input  wire logic                option_wr_i,
    input  wire logic [7:0]          option_data_i,
    input  wire logic                dir_gp_wr_i,
    input  wire logic                dir_c_wr_i,
    input  wire logic [5:0]          dir_data_i,
    input  wire logic                watchdog_clear_op_i,
    input  wire logic                external_count_input_i,
    output logic [7:0]               reg_rdata_o,
    output logic [7:0]               timer_count_o,
    output logic [7:0]               option_o,
    output logic [5:0]               direction_gp_o,
    output logic [5:0]               direction_c_o,
    output logic                     count_pin_input_o,
    output logic                     watchdog_tick_o,
    output logic [PRESCALER_W-1:0]   watchdog_post_o
);
    logic [1:0]             phase;
    logic                   cycle_end;
    logic [COUNT_W-1:0]     count_r;
    logic [COUNT_W-1:0]     count_nxt;
    logic [7:0]             option_r;
    logic [5:0]             dir_gp_r;
    logic [5:0]             dir_c_r;
    logic [1:0]             inhibit_r;
    logic                   ext_edge_r;
    logic                   src_prev_r;
    logic                   sample_r;
    logic                   sample_prev_r;
    logic                   pre_clear;
    logic                   pre_tick;
    logic [PRESCALER_W-1:0] pre_count;
    logic                   pre_out_prev_r;
    logic                   pre_out;
    logic                   clk_src_sel;
    logic                   edge_sel;
    logic                   to_watchdog;
    logic [2:0]             ratio;
    logic                   count_write;
    logic                   raw_tick;
    logic                   count_tick;
    logic [7:0]             rdata_r;
    logic                   wd_tick_r;
    logic                   pin_input_r;

    // option fields
    assign clk_src_sel = option_r[tmq_pkg::OPT_CLOCK_SRC_BIT];
    assign edge_sel    = option_r[tmq_pkg::OPT_EDGE_BIT];
    assign to_watchdog = option_r[tmq_pkg::OPT_ASSIGN_BIT];
    assign ratio       = option_r[tmq_pkg::OPT_RATIO_LSB +: tmq_pkg::OPT_RATIO_W];
    assign count_write = reg_wr_i && (reg_addr_i == tmq_pkg::TIMER_COUNT_ADDR);

    // picks the prescaler bit whose toggle gives divide by 2^(n+1)
    function automatic logic ratio_tap(input logic [PRESCALER_W-1:0] cnt,
                                       input logic [2:0] n);
        ratio_tap = cnt[n];
    endfunction

    tmq_phase_gen u_phase (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .phase_o     (phase),
        .cycle_end_o (cycle_end)
    );

    // edge detect on the selected source edge of the pin
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_prev_r <= 1'b0;
        end else begin
            src_prev_r <= external_count_input_i;
        end
    end
    always_comb begin
        if (edge_sel) begin
            ext_edge_r = src_prev_r && !external_count_input_i;
        end else begin
            ext_edge_r = !src_prev_r && external_count_input_i;
        end
    end

    // prescaler clocking: source is pin edge or instruction cycle; watchdog
    // ticks are fed back here only as cycle strobes (watchdog outside block)
    always_comb begin
        if (to_watchdog) begin
            pre_tick  = cycle_end;
            pre_clear = watchdog_clear_op_i;
        end else begin
            pre_tick  = clk_src_sel ? ext_edge_r : cycle_end;
            pre_clear = count_write;
        end
    end

    tmq_prescaler #(
        .WIDTH (PRESCALER_W)
    ) u_pre (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .clear_i (pre_clear),
        .tick_i  (pre_tick),
        .count_o (pre_count)
    );

    // prescaler output: tapped divider bit when assigned to timer
    assign pre_out = ratio_tap(pre_count, ratio);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_out_prev_r <= 1'b0;
        end else begin
            pre_out_prev_r <= pre_out;
        end
    end

    // counter mode: sample source in second and fourth phases
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_r      <= 1'b0;
            sample_prev_r <= 1'b0;
        end else if (phase == tmq_pkg::PHASE_SECOND || phase == tmq_pkg::PHASE_FOURTH) begin
            sample_prev_r <= sample_r;
            if (to_watchdog) begin
                sample_r <= edge_sel ? !external_count_input_i : external_count_input_i;
            end else begin
                sample_r <= !pre_out; // falling tap edge closes a full ratio
            end
        end
    end

    // increment strobe for the count register
    always_comb begin
        if (!clk_src_sel) begin
            if (to_watchdog) begin
                raw_tick = cycle_end;
            end else begin
                raw_tick = pre_out_prev_r && !pre_out;
            end
        end else begin
            // each sampled pair is judged once, on the edge that replaces it
            raw_tick = sample_r && !sample_prev_r
                       && (phase == tmq_pkg::PHASE_SECOND || phase == tmq_pkg::PHASE_FOURTH);
        end
        count_tick = raw_tick && (inhibit_r == 2'd0);
    end

    // two-cycle inhibit after a count write
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            inhibit_r <= 2'd0;
        end else if (count_write) begin
            inhibit_r <= tmq_pkg::INHIBIT_CYCLES;
        end else if (cycle_end && inhibit_r != 2'd0) begin
            inhibit_r <= inhibit_r - 2'd1;
        end
    end

    // count register: no reset, keeps value across resets
    always_comb begin
        if (count_write) begin
            count_nxt = reg_wdata_i[COUNT_W-1:0];
        end else if (count_tick) begin
            count_nxt = count_r + {{(COUNT_W-1){1'b0}}, 1'b1};
        end else begin
            count_nxt = count_r;
        end
    end
    always_ff @(posedge clk_i) begin
        count_r <= count_nxt;
    end

    // option and direction registers, write only
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            option_r <= tmq_pkg::OPTION_RESET;
            dir_gp_r <= tmq_pkg::DIR_RESET;
            dir_c_r  <= tmq_pkg::DIR_RESET;
            pin_input_r <= tmq_pkg::OPTION_RESET[tmq_pkg::OPT_CLOCK_SRC_BIT]
                           || tmq_pkg::DIR_RESET[5];
        end else begin
            // count pin direction follows the next option and direction values
            pin_input_r <= (option_wr_i ? option_data_i[tmq_pkg::OPT_CLOCK_SRC_BIT] : clk_src_sel)
                           || (dir_c_wr_i ? dir_data_i[5] : dir_c_r[5]);
            if (option_wr_i) begin
                option_r <= option_data_i;
            end
            if (dir_gp_wr_i) begin
                dir_gp_r <= dir_data_i;
            end
            if (dir_c_wr_i) begin
                dir_c_r <= dir_data_i;
            end
        end
    end

    // read data: count only, prescaler has no read path
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= 8'h00;
        end else if (reg_rd_i) begin
            if (reg_addr_i == tmq_pkg::TIMER_COUNT_ADDR) begin
                rdata_r <= count_nxt;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    // watchdog postscaler strobe
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wd_tick_r <= 1'b0;
        end else begin
            wd_tick_r <= to_watchdog && pre_tick && (pre_count == '1);
        end
    end

    assign reg_rdata_o       = rdata_r;
    assign timer_count_o     = count_r;
    assign option_o          = option_r;
    assign direction_gp_o    = dir_gp_r;
    assign direction_c_o     = dir_c_r;
    assign count_pin_input_o = pin_input_r;
    assign watchdog_tick_o   = wd_tick_r;
    assign watchdog_post_o   = pre_count;
endmodule

/* tb/tmq_timer_properties.sv */
`timescale 1ns/1ps
// port-level checks on the timer, bound into every instance
module tmq_timer_checker #(
    parameter int PRESCALER_W = 8
) (
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    input  wire logic                   option_wr_i,
    input  wire logic [7:0]             option_data_i,
    input  wire logic                   watchdog_clear_op_i,
    input  wire logic [7:0]             reg_rdata_o,
    input  wire logic [7:0]             timer_count_o,
    input  wire logic [7:0]             option_o,
    input  wire logic                   count_pin_input_o,
    input  wire logic [PRESCALER_W-1:0] watchdog_post_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // timer mode, prescaler on the watchdog, no register or option writes
    logic quiet;
    assign quiet = !reg_wr_i && !option_wr_i && option_o[5:3] == 3'b001;

    unmapped_read_a: assert property (reg_rd_i && reg_addr_i != 8'h01 |=>
        reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    count_read_a: assert property (reg_rd_i && reg_addr_i == 8'h01 |=>
        reg_rdata_o == $past(timer_count_o)) else $error("count read wrong");
    count_write_a: assert property (reg_wr_i && reg_addr_i == 8'h01 |=>
        timer_count_o == $past(reg_wdata_i)) else $error("count write lost");
    write_inhibit_a: assert property (reg_wr_i && reg_addr_i == 8'h01 ##1
        (!reg_wr_i)[*5] |-> timer_count_o == $past(timer_count_o, 4))
        else $error("count moved during inhibit");
    single_step_a: assert property (!$stable(timer_count_o) && !$past(reg_wr_i) |->
        timer_count_o == $past(timer_count_o) + 8'h01) else $error("count step not one");
    timer_rate_a: assert property (quiet[*8] ##1 quiet[*4] |->
        timer_count_o == $past(timer_count_o, 4) + 8'h01) else $error("timer rate wrong");
    option_load_a: assert property (option_wr_i |=> option_o == $past(option_data_i))
        else $error("option word not loaded");
    pin_override_a: assert property (option_o[5] |-> count_pin_input_o)
        else $error("count pin not input");
    wdt_clear_a: assert property (watchdog_clear_op_i && option_o[3] |=>
        watchdog_post_o == '0) else $error("postscaler not cleared");
endmodule

bind tmq_timer tmq_timer_checker #(.PRESCALER_W(PRESCALER_W)) u_chk (.*);

/* tb/tmq_pin_src.sv */
`timescale 1ns/1ps
// external count source: square wave, always comes to rest low
module tmq_pin_src #(
    parameter int HALF = 4
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      pin_o,
    output int        rises_o,
    output int        falls_o
);
    int cnt_r;
    initial begin
        pin_o = 1'b0;
        cnt_r = 0;
        rises_o = 0;
        falls_o = 0;
    end
    // each level is held HALF oscillator periods, above the minimum
    always @(negedge clk_i) begin
        if (!run_i && !pin_o) begin
            cnt_r <= 0;
        end else if (cnt_r != HALF - 1) begin
            cnt_r <= cnt_r + 1;
        end else begin
            cnt_r <= 0;
            pin_o <= !pin_o;
            rises_o <= rises_o + int'(!pin_o);
            falls_o <= falls_o + int'(pin_o);
        end
    end
endmodule

/* tb/tb_eight_bit_timer_with_shared_prescaler.sv */
`timescale 1ns/1ps
module tb_eight_bit_timer_with_shared_prescaler;
    logic       clk_i = 0, rstn_i = 0, wr = 0, rd = 0, owr = 0, gwr = 0, cwr = 0, wdc = 0;
    logic       run = 0, pin, pin_in, tick;
    logic [7:0] addr = 0, wdata = 0, odata = 0, rdata, count, option, wpost, d, c;
    logic [5:0] ddata = 0, dgp, dc;
    int         n_mismatch = 0, checks = 0, rises, falls, r0, n, k, need;

    initial forever #2.5 clk_i = ~clk_i;

    tmq_timer u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .option_wr_i(owr), .option_data_i(odata),
        .dir_gp_wr_i(gwr), .dir_c_wr_i(cwr), .dir_data_i(ddata), .watchdog_clear_op_i(wdc),
        .external_count_input_i(pin), .reg_rdata_o(rdata), .timer_count_o(count),
        .option_o(option), .direction_gp_o(dgp), .direction_c_o(dc),
        .count_pin_input_o(pin_in), .watchdog_tick_o(tick), .watchdog_post_o(wpost));
    tmq_pin_src u_src (.clk_i(clk_i), .run_i(run), .pin_o(pin), .rises_o(rises),
        .falls_o(falls));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one-cycle strobe on the register at address a or on the option word
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v, input logic o);
        @(negedge clk_i);
        addr = a;
        wdata = v;
        odata = v;
        wr = !o;
        owr = o;
        @(negedge clk_i);
        wr = 0;
        owr = 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        addr = a;
        rd = 1;
        @(negedge clk_i);
        rd = 0;
        cmp(rdata, exp);
    endtask
    // one watchdog clear pulse
    task automatic wd_clear;
        @(negedge clk_i);
        wdc = 1;
        @(negedge clk_i);
        wdc = 0;
    endtask
    // count edges until the count moves, bounded
    task automatic wait_move(input int lim);
        c = count;
        n = 0;
        while (count === c && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= lim) begin
            n_mismatch++;
            finish_test();
        end
    endtask

    initial begin
        void'($urandom(32'h6f537fff));
        repeat (3) @(negedge clk_i);
        rstn_i = 1;
        cmp(option, 8'hff);
        cmp(wpost, 8'h00);
        cmp(8'(pin_in), 8'h01);
        cmp(8'(dgp), 8'h3f);
        d = 8'($urandom);
        @(negedge clk_i);
        ddata = d[5:0];
        gwr = 1;
        @(negedge clk_i);
        ddata = 6'h1f;
        gwr = 0;
        cwr = 1;
        @(negedge clk_i);
        cwr = 0;
        cmp(8'(dgp), 8'(d[5:0]));
        cmp(8'(dc), 8'h1f);
        $display("test reset and direction done");
        // timer mode, no prescaler: inhibit, wrap, one step per cycle
        wr_reg(8'h00, 8'h08, 1);
        cmp(8'(pin_in), 8'h00);
        wr_reg(8'h01, 8'hff, 0);
        wait_move(20);
        cmp(8'(n >= 8 && n <= 12), 8'h01);
        cmp(count, 8'h00);
        wait_move(20);
        cmp(8'(n), 8'h04);
        // timer mode with prescaler 1:4: one step every four instruction cycles
        wd_clear();
        wr_reg(8'h00, 8'h01, 1);
        wr_reg(8'h01, 8'h00, 0);
        wait_move(60);
        wait_move(60);
        cmp(8'(n), 8'h10);
        for (k = 0; k < 4; k++) begin
            d = 8'($urandom);
            wr_reg(8'h01, d, 0);
            rd_reg(8'h01, d);
            wr_reg(8'($urandom) | 8'h02, 8'($urandom), 0);
            rd_reg(8'($urandom) | 8'h02, 8'h00);
            rd_reg(8'h01, d);
        end
        $display("test timer mode done");
        // counter mode: both edges, then every prescale ratio
        for (k = 0; k < 10; k++) begin
            wd_clear();
            wr_reg(8'h00, (k < 2) ? 8'h28 | 8'(k << 4) : 8'h20 | 8'(k - 2), 1);
            wr_reg(8'h01, 8'h00, 0);
            repeat (12) @(negedge clk_i);
            need = (k < 2) ? 5 : 7 << (k - 2);
            r0 = rises;
            run = 1;
            for (n = 0; n < 8000 && rises - r0 < need; n++) @(negedge clk_i);
            run = 0;
            if (rises - r0 < need) begin
                n_mismatch++;
                finish_test();
            end
            repeat (20) @(negedge clk_i);
            cmp(count, (k < 2) ? 8'h05 : 8'h03);
            cmp(8'(pin_in), 8'h01);
        end
        $display("test counter mode done");
        // watchdog clear, then reset in mid-run keeps the count
        wd_clear();
        wr_reg(8'h01, 8'h00, 0);
        wr_reg(8'h00, 8'h0f, 1);
        @(negedge clk_i);
        wdc = 1;
        @(negedge clk_i);
        wdc = 0;
        cmp(wpost, 8'h00);
        d = count;
        rstn_i = 0;
        @(negedge clk_i);
        cmp(wpost, 8'h00);
        cmp(option, 8'hff);
        rstn_i = 1;
        cmp(count, d);
        $display("test watchdog and reset done");
        finish_test();
    end
endmodule
